// >>> hw/_end.v
`timescale 1ns/1ps

// >>> hw/sadcfp_consts.vh
// constants for the serial converter frame port
// Function
// - result pin floats while select high
// - select low presents first result bit
// - result bit changes on shift falling edge
// - eleven further result bits follow
// - eight command bits on first rises
// - channel address usable after fourth rise
// - sampling from fourth to last fall
// - last fall hands over to converter
// - end flag drops after last fall
// - end flag low through conversion
// - end flag high when result ready
// - select edges reset and gate frame
`ifndef SADCFP_CONSTS_VH
`define SADCFP_CONSTS_VH
`define SADCFP_RES_W 12
`define SADCFP_CMD_W 8
`define SADCFP_ADDR_W 4
`define SADCFP_CNT_W 4
`define SADCFP_CMD_BITS 4'h8
`define SADCFP_ADDR_EDGE 4'h4
`define SADCFP_SAMPLE_FALL 4'h4
`define SADCFP_LAST_FALL 4'hC
`define SADCFP_ADDR_MSB 7
`define SADCFP_ADDR_LSB 4
`define SADCFP_LEN_MSB 3
`define SADCFP_LEN_LSB 2
`define SADCFP_LSBF_BIT 1
`define SADCFP_BIPOLAR_BIT 0
`define SADCFP_RST_RESULT 12'h000
`define SADCFP_RST_CMD 8'h00
`endif

// >>> hw/sadcfp_port.v
// serial frame port of a 12-bit converter: select, shift clock, command in, result out
`timescale 1ns/1ps
`default_nettype none
`include "sadcfp_consts.vh"
module sadcfp_port (
  input wire clk_sys,
  input wire arst_n,

  input wire sel_n,
  input wire sclk,
  input wire cmd_in,

  output wire dout_o,
  output wire dout_oe,
  output reg eoc,

  output reg [`SADCFP_ADDR_W-1:0] mux_addr,
  output reg mux_addr_valid,
  output reg sampling,
  output reg conv_start,
  output reg [`SADCFP_CMD_W-1:0] cmd_word,
  output reg cmd_valid,
  output reg frame_abort,

  input wire conv_done,
  input wire [`SADCFP_RES_W-1:0] conv_result
);

  // ****************************************
  // pin synchronisers
  // ****************************************

  reg sel_m;
  reg sel_s;
  reg sclk_m;
  reg sclk_s;
  reg sclk_d;
  reg cmd_m;
  reg cmd_s;
  reg sel_d;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_m <= 1'b1;
      sel_s <= 1'b1;
      sel_d <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      cmd_m <= 1'b0;
      cmd_s <= 1'b0;
    end else begin
      sel_m <= sel_n;
      sel_s <= sel_m;
      sel_d <= sel_s;
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      cmd_m <= cmd_in;
      cmd_s <= cmd_m;
    end
  end

  // ****************************************
  // edge detection
  // ****************************************

  wire sel_fall;
  wire sel_rise;
  wire active;
  wire sclk_rise;
  wire sclk_fall;

  assign sel_fall = sel_d & ~sel_s;
  assign sel_rise = ~sel_d & sel_s;
  assign active = ~sel_s & ~sel_d;
  // shift clock edges count only inside an open frame
  assign sclk_rise = active & sclk_s & ~sclk_d;
  assign sclk_fall = active & ~sclk_s & sclk_d;

  // ****************************************
  // frame counters
  // ****************************************

  reg [`SADCFP_CNT_W-1:0] rise_cnt;
  reg [`SADCFP_CNT_W-1:0] fall_cnt;
  reg frame_done;

  wire [`SADCFP_CNT_W-1:0] next_rise_cnt;
  wire [`SADCFP_CNT_W-1:0] next_fall_cnt;
  wire cmd_take;
  wire fall_take;
  wire last_fall;

  assign next_rise_cnt = rise_cnt + 4'h1;
  assign next_fall_cnt = fall_cnt + 4'h1;
  assign cmd_take = sclk_rise & (rise_cnt < `SADCFP_CMD_BITS);
  assign fall_take = sclk_fall & ~frame_done;
  assign last_fall = fall_take & (next_fall_cnt == `SADCFP_LAST_FALL);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rise_cnt <= 4'h0;
      fall_cnt <= 4'h0;
      frame_done <= 1'b0;
    end else if (sel_fall) begin
      rise_cnt <= 4'h0;
      fall_cnt <= 4'h0;
      frame_done <= 1'b0;
    end else begin
      if (cmd_take) begin
        rise_cnt <= next_rise_cnt;
      end
      if (fall_take) begin
        fall_cnt <= next_fall_cnt;
      end
      if (last_fall) begin
        frame_done <= 1'b1;
      end
    end
  end

  // ****************************************
  // command capture
  // ****************************************

  reg [`SADCFP_CMD_W-1:0] cmd_sr;
  reg lsb_first;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_sr <= `SADCFP_RST_CMD;
      cmd_word <= `SADCFP_RST_CMD;
      cmd_valid <= 1'b0;
      mux_addr <= 4'h0;
      mux_addr_valid <= 1'b0;
    end else if (sel_fall) begin
      cmd_sr <= `SADCFP_RST_CMD;
      cmd_valid <= 1'b0;
      mux_addr_valid <= 1'b0;
    end else if (cmd_take) begin
      cmd_sr <= {cmd_sr[`SADCFP_CMD_W-2:0], cmd_s};
      if (next_rise_cnt == `SADCFP_ADDR_EDGE) begin
        mux_addr <= {cmd_sr[2:0], cmd_s};
        mux_addr_valid <= 1'b1;
      end
      if (next_rise_cnt == `SADCFP_CMD_BITS) begin
        cmd_word <= {cmd_sr[`SADCFP_CMD_W-2:0], cmd_s};
        cmd_valid <= 1'b1;
      end
    end
  end

  // bit order chosen by a completed command takes effect from the next frame
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lsb_first <= 1'b0;
    end else if (last_fall & cmd_valid) begin
      lsb_first <= cmd_word[`SADCFP_LSBF_BIT];
    end
  end

  // ****************************************
  // sampling window and hand-over
  // ****************************************

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sampling <= 1'b0;
      conv_start <= 1'b0;
      frame_abort <= 1'b0;
    end else begin
      conv_start <= last_fall;
      frame_abort <= sel_rise & ~frame_done;
      if (sel_fall | sel_rise) begin
        sampling <= 1'b0;
      end else if (last_fall) begin
        sampling <= 1'b0;
      end else if (fall_take & (next_fall_cnt == `SADCFP_SAMPLE_FALL)) begin
        sampling <= 1'b1;
      end
    end
  end

  // ****************************************
  // conversion status and result
  // ****************************************

  reg [`SADCFP_RES_W-1:0] result;
  reg converting;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      eoc <= 1'b1;
      converting <= 1'b0;
      result <= `SADCFP_RST_RESULT;
    end else if (last_fall) begin
      // a new conversion wins over a done strobe in the same cycle
      eoc <= 1'b0;
      converting <= 1'b1;
    end else if (converting & conv_done) begin
      result <= conv_result;
      eoc <= 1'b1;
      converting <= 1'b0;
    end else if (converting) begin
      eoc <= 1'b0;
    end
  end

  // ****************************************
  // serial result output
  // ****************************************

  wire out_shift;

  // only falls 1..11 advance the output; the 12th starts conversion
  assign out_shift = fall_take & ~last_fall;

  sadcfp_shift u_shift (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(sel_fall),
    .shift(out_shift),
    .lsb_first(lsb_first),
    .data(result),
    .bit_out(dout_o)
  );

  // drive the pin only while the frame is open
  assign dout_oe = ~sel_s & ~sel_d;

endmodule
`default_nettype wire

// >>> hw/sadcfp_shift.v
// result shift register that feeds the serial result pin
`timescale 1ns/1ps
`default_nettype none
`include "sadcfp_consts.vh"
module sadcfp_shift (
  input wire clk_sys,
  input wire arst_n,
  input wire load,
  input wire shift,
  input wire lsb_first,
  input wire [`SADCFP_RES_W-1:0] data,
  output reg bit_out
);
  reg [`SADCFP_RES_W-1:0] sr;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sr <= `SADCFP_RST_RESULT;
      bit_out <= 1'b0;
    end else if (load) begin
      sr <= data;
      bit_out <= lsb_first ? data[0] : data[`SADCFP_RES_W-1];
    end else if (shift) begin
      if (lsb_first) begin
        sr <= {1'b0, sr[`SADCFP_RES_W-1:1]};
        bit_out <= sr[1];
      end else begin
        sr <= {sr[`SADCFP_RES_W-2:0], 1'b0};
        bit_out <= sr[`SADCFP_RES_W-2];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/sadcfp_host.sv
// host serial port model of the frame port
`timescale 1ns/1ps
`default_nettype none
module sadcfp_host (
  input wire logic clk_sys,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic eoc,
  output logic sel_n = 1'b1,
  output logic sclk = 1'b0,
  output logic cmd_in = 1'b0
);
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic frame(input logic [7:0] cmd, input int n, output logic [11:0] res,
    output logic oe);
    int i;
    i = 0;
    oe = 1'b1;
    while (eoc !== 1'b1 && i < 2000) begin
      step(1);
      i++;
    end
    sel_n = 1'b0;
    for (i = 0; i < n; i++) begin
      cmd_in = (i < 8) ? cmd[7-i] : ~cmd_in;
      step(4);
      res = {res[10:0], dout_o};
      oe = oe & dout_oe;
      sclk = 1'b1;
      step(4);
      sclk = 1'b0;
    end
    step(4);
    sel_n = 1'b1;
    cmd_in = ~cmd_in;
  endtask
endmodule
`default_nettype wire

// >>> verif/sadcfp_port_props.sv
// checker of the serial converter frame port
`timescale 1ns/1ps
`default_nettype none
module sadcfp_port_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic eoc,
  input wire logic [3:0] mux_addr,
  input wire logic mux_addr_valid,
  input wire logic sampling,
  input wire logic conv_start,
  input wire logic [7:0] cmd_word,
  input wire logic cmd_valid,
  input wire logic conv_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_done;
    !eoc && conv_done;
  endsequence
  a_float_idle: assert property (sel_n [*5] |-> !dout_oe)
    else $error("pin driven idle");
  a_bit_fall: assert property ($changed(dout_o) && dout_oe && $past(dout_oe) |-> !$past(sclk))
    else $error("bit moved off fall");
  a_cmd_addr: assert property ($rose(cmd_valid) |-> mux_addr_valid && mux_addr == cmd_word[7:4])
    else $error("command word");
  a_addr_hold: assert property (!$rose(mux_addr_valid) |-> $stable(mux_addr))
    else $error("address moved");
  a_sample_addr: assert property (sampling |-> mux_addr_valid)
    else $error("sampling early");
  a_hand_over: assert property (conv_start |-> $past(sampling) && !sampling && !eoc)
    else $error("hand over");
  a_eoc_low: assert property (!eoc && !conv_done |=> !eoc)
    else $error("end flag early");
  a_eoc_done: assert property (s_done |=> eoc)
    else $error("end flag late");
  a_oe_release: assert property ($rose(sel_n) |-> ##[1:5] !dout_oe)
    else $error("pin not released");
endmodule
bind sadcfp_port sadcfp_port_chk chk_u (.clk_sys, .arst_n, .sel_n, .sclk, .dout_o, .dout_oe,
  .eoc, .mux_addr, .mux_addr_valid, .sampling, .conv_start, .cmd_word, .cmd_valid, .conv_done);
`default_nettype wire

// >>> verif/sadcfp_port_test.sv
// testbench of the serial converter frame port
`timescale 1ns/1ps
`default_nettype none
module sadcfp_port_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic conv_done = 1'b0;
  logic [11:0] conv_result = 12'h000;
  wire sel_n, sclk, cmd_in, dout_o, dout_oe, eoc, mux_addr_valid, sampling, conv_start, cmd_valid;
  wire [3:0] mux_addr;
  wire [7:0] cmd_word;
  wire frame_abort;
  int n_abort = 0;
  int errors = 0;
  int n_compared = 0;
  int busy = 0;
  logic [11:0] rd;
  logic oe;
  always #10 clk_sys = ~clk_sys;
  sadcfp_port dut_u (.clk_sys, .arst_n, .sel_n, .sclk, .cmd_in, .dout_o, .dout_oe, .eoc,
    .mux_addr, .mux_addr_valid, .sampling, .conv_start, .cmd_word, .cmd_valid,
    .frame_abort, .conv_done, .conv_result);
  always @(posedge clk_sys) if (frame_abort === 1'b1) n_abort++;
  sadcfp_host host_u (.clk_sys, .dout_o, .dout_oe, .eoc, .sel_n, .sclk, .cmd_in);
  // converter core answers 20 cycles after start
  always @(posedge clk_sys) begin
    conv_done <= #1 (busy == 1);
    busy <= #1 conv_start ? 20 : (busy > 0 ? busy - 1 : 0);
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  function automatic logic [11:0] rev(input logic [11:0] v);
    for (int i = 0; i < 12; i++) rev[i] = v[11-i];
  endfunction
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_first;
    host_u.frame(8'hA0, 12, rd, oe);
    chk(rd === 12'h000 && oe === 1'b1, "first result");
    chk(mux_addr === 4'hA && cmd_word === 8'hA0 && cmd_valid === 1'b1, "cmd");
    chk(eoc === 1'b0, "eoc low");
    conv_result = 12'hC35;
    repeat (30) @(posedge clk_sys);
    #1 chk(eoc === 1'b1, "eoc high");
  endtask
  task automatic t_orders;
    host_u.frame(8'h52, 12, rd, oe);
    chk(rd === 12'hC35, "msb first");
    conv_result = 12'h3A1;
    host_u.frame(8'h30, 12, rd, oe);
    chk(rd === rev(12'h3A1), "lsb first");
    chk(mux_addr === 4'h3 && sampling === 1'b0, "addr");
    chk(n_abort == 0, "no abort on full frames");
  endtask
  task automatic t_abort;
    host_u.frame(8'h70, 6, rd, oe);
    repeat (5) @(posedge clk_sys);
    #1 chk(eoc === 1'b1 && dout_oe === 1'b0 && conv_start === 1'b0, "abort");
    chk(n_abort == 1, "abort pulse");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(eoc === 1'b1 && dout_oe === 1'b0, "reset");
    t_first();
    t_orders();
    t_abort();
    tally_and_finish();
  end
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
